// ===== hdl/sdac_top.sv
// front end of a single channel 16 bit serial converter: serial input, registers, latch
//
// Summary of operation
// - latch follows input register while load low
// - output code is the latch, no extra stage
// - reset code 8000h or 0000h by level select
// - format select high straight, low two's complement
// - reset low reloads registers with selected value
// - power-down high disconnects output from converter
// - shift bits only while chip select low
// - serial output high impedance while chip select high
// - stand-alone mode shifts input register out
// - daisy-chain mode shifts shift register out
// - words, input register and latch are 16 bits
// - output stays at reset level until write while format select high
`timescale 1ns/1ns
`default_nettype none

module sdac_top (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  input wire logic latch_load_n_i,
  input wire logic reset_level_select_i,
  input wire logic data_format_select_i,
  input wire logic power_down_in_i,
  input wire logic serial_out_select_i,
  output logic [sdac_pkg::WORD_W-1:0] dac_code_o,
  output logic power_down_o,
  output logic [sdac_pkg::WORD_W-1:0] input_word_o,
  output logic word_taken_o,
  output logic partial_word_o,
  output logic latch_update_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // system clock state

  typedef struct packed {
    sdac_pkg::sdac_pins_type pin_meta;
    sdac_pkg::sdac_pins_type pin_sync;
    sdac_pkg::sdac_frame_type frame;
    logic consumed;
    logic [sdac_pkg::WORD_W-1:0] input_word;
    logic [sdac_pkg::WORD_W-1:0] latch_word;
    logic power_down;
    logic word_taken;
    logic partial_word;
    logic latch_update;
  } sdac_state_type;

  sdac_state_type state_reg;
  sdac_state_type state_next;

  sdac_pkg::sdac_pins_type pins_raw;
  sdac_pkg::sdac_link_type link_word;
  logic link_clear;
  logic link_sdo;
  logic [sdac_pkg::WORD_W-1:0] latch_source;

  ////////////////////////////////////////////////////////////////////////////////
  // pin gathering

  always_comb begin
    pins_raw.cs_n = cs_n_i;
    pins_raw.latch_load_n = latch_load_n_i;
    pins_raw.reset_level_select = reset_level_select_i;
    pins_raw.data_format_select = data_format_select_i;
    pins_raw.power_down_in = power_down_in_i;
    pins_raw.serial_out_select = serial_out_select_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial clock domain

  // the clear drops the instant chip select falls, so no serial edge of the
  // frame is swallowed while the synchronised chip select is still catching up
  assign link_clear = state_reg.consumed & cs_n_i;

  sdac_shift u_shift (
    .sclk_i(sclk_i),
    .clear_i(link_clear),
    .cs_n_i(cs_n_i),
    .sdi_i(sdi_i),
    .serial_out_select_i(state_reg.pin_sync.serial_out_select),
    .readback_i(state_reg.input_word),
    .link_o(link_word),
    .sdo_o(link_sdo)
  );

  assign sdo_o = link_sdo;
  assign sdo_oe_n_o = cs_n_i;

  ////////////////////////////////////////////////////////////////////////////////
  // latch source with format conversion

  always_comb begin
    latch_source = sdac_pkg::to_offset_binary(state_reg.input_word,
                                              state_reg.pin_sync.data_format_select);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_next = state_reg;
    state_next.pin_meta = pins_raw;
    state_next.pin_sync = state_reg.pin_meta;
    state_next.word_taken = 1'b0;
    state_next.partial_word = 1'b0;
    state_next.latch_update = 1'b0;

    if (!rst_n_i) begin
      state_next.frame = sdac_pkg::SDAC_IDLE;
      state_next.consumed = 1'b1;
      state_next.input_word = sdac_pkg::reset_code(state_reg.pin_sync.reset_level_select);
      state_next.latch_word = sdac_pkg::reset_code(state_reg.pin_sync.reset_level_select);
      state_next.power_down = 1'b0;
    end else begin
      state_next.power_down = state_reg.pin_sync.power_down_in;

      // frame tracking on the synchronised chip select
      case (state_reg.frame)
        sdac_pkg::SDAC_IDLE: begin
          if (!state_reg.pin_sync.cs_n) begin
            state_next.frame = sdac_pkg::SDAC_FRAME;
            state_next.consumed = 1'b0;
          end
        end
        sdac_pkg::SDAC_FRAME: begin
          if (state_reg.pin_sync.cs_n) begin
            // serial clock has stopped: the shift side is quiet and safe to read
            state_next.frame = sdac_pkg::SDAC_DONE;
            if (sdac_pkg::word_complete(link_word.count)) begin
              state_next.input_word = link_word.shift;
              state_next.word_taken = 1'b1;
            end else begin
              state_next.partial_word = 1'b1;
            end
          end
        end
        sdac_pkg::SDAC_DONE: begin
          state_next.consumed = 1'b1;
          state_next.frame = sdac_pkg::SDAC_IDLE;
        end
        default: begin
          state_next.frame = sdac_pkg::SDAC_IDLE;
          state_next.consumed = 1'b1;
        end
      endcase

      // transparent latch while load is held low
      if (!state_reg.pin_sync.latch_load_n) begin
        state_next.latch_word = latch_source;
        state_next.latch_update = (latch_source != state_reg.latch_word);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register

  always_ff @(posedge clock_i) begin
    state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign dac_code_o = state_reg.latch_word;
  assign power_down_o = state_reg.power_down;
  assign input_word_o = state_reg.input_word;
  assign word_taken_o = state_reg.word_taken;
  assign partial_word_o = state_reg.partial_word;
  assign latch_update_o = state_reg.latch_update;

endmodule

`default_nettype wire

// ===== hdl/sdac_pkg.sv
// shared constants, carrier types and helper functions for the serial converter front end
package sdac_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam int SYNC_W = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // codes and counts
  localparam logic [WORD_W-1:0] RESET_CODE_MID = 16'h8000;
  localparam logic [WORD_W-1:0] RESET_CODE_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] MSB_MASK = 16'h8000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_TOP_BIT = 5'h0f;

  ////////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic cs_n;
    logic latch_load_n;
    logic reset_level_select;
    logic data_format_select;
    logic power_down_in;
    logic serial_out_select;
  } sdac_pins_type;

  typedef struct packed {
    logic [WORD_W-1:0] shift;
    logic [CNT_W-1:0] count;
  } sdac_link_type;

  typedef enum logic [1:0] {
    SDAC_IDLE = 2'b00,
    SDAC_FRAME = 2'b01,
    SDAC_DONE = 2'b10
  } sdac_frame_type;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [WORD_W-1:0] reset_code(input logic level_sel);
    reset_code = level_sel ? RESET_CODE_MID : RESET_CODE_ZERO;
  endfunction

  function automatic logic [WORD_W-1:0] to_offset_binary(input logic [WORD_W-1:0] word,
                                                          input logic straight);
    to_offset_binary = straight ? word : (word ^ MSB_MASK);
  endfunction

  function automatic logic word_complete(input logic [CNT_W-1:0] count);
    word_complete = (count == CNT_FULL);
  endfunction

endpackage

// ===== hdl/sdac_shift.sv
// serial clock domain: input shift register, bit counter and serial output mux
`timescale 1ns/1ns
`default_nettype none

module sdac_shift (
  input wire logic sclk_i,
  input wire logic clear_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic serial_out_select_i,
  input wire logic [sdac_pkg::WORD_W-1:0] readback_i,
  output sdac_pkg::sdac_link_type link_o,
  output logic sdo_o
);

  sdac_pkg::sdac_link_type state_reg;
  sdac_pkg::sdac_link_type state_next;
  logic [sdac_pkg::CNT_W-1:0] out_index;

  ////////////////////////////////////////////////////////////////////////////////
  // shift on rising edges, count saturates at one full word
  always_comb begin
    state_next = state_reg;
    if (!cs_n_i) begin
      state_next.shift = {state_reg.shift[sdac_pkg::WORD_W-2:0], sdi_i};
      if (!sdac_pkg::word_complete(state_reg.count)) begin
        state_next.count = state_reg.count + sdac_pkg::CNT_ONE;
      end
    end
  end

  // cleared between frames by the system side once it has taken the word
  always_ff @(posedge sclk_i or posedge clear_i) begin
    if (clear_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial output source
  assign out_index = sdac_pkg::CNT_TOP_BIT - state_reg.count;

  always_comb begin
    if (!serial_out_select_i) begin
      sdo_o = state_reg.shift[sdac_pkg::WORD_W-1];
    end else if (sdac_pkg::word_complete(state_reg.count)) begin
      sdo_o = 1'b0;
    end else begin
      sdo_o = readback_i[out_index[sdac_pkg::CNT_W-2:0]];
    end
  end

  assign link_o = state_reg;

endmodule

`default_nettype wire

// ===== sim/sdac_top_monitor.sv
// assertion checker for the serial converter front end
`timescale 1ns/1ns
`default_nettype none
module sdac_top_monitor (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_n_o,
  input wire logic latch_load_n_i,
  input wire logic reset_level_select_i,
  input wire logic data_format_select_i,
  input wire logic power_down_in_i,
  input wire logic serial_out_select_i,
  input wire logic [sdac_pkg::WORD_W-1:0] dac_code_o,
  input wire logic power_down_o,
  input wire logic [sdac_pkg::WORD_W-1:0] input_word_o,
  input wire logic word_taken_o,
  input wire logic partial_word_o,
  input wire logic latch_update_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_oe_follows_cs: assert property (sdo_oe_n_o == cs_n_i)
    else $error("sdo enable differs from chip select");
  a_reset_code_out: assert property ($rose(rst_n_i) |-> dac_code_o == {reset_level_select_i,
    15'h0000} && input_word_o == {reset_level_select_i, 15'h0000}) else $error("bad reset code");
  a_frame_answered: assert property ($rose(cs_n_i) |-> ##[1:5] (word_taken_o || partial_word_o))
    else $error("frame end not answered");
  a_taken_one_cycle: assert property (word_taken_o |=> !word_taken_o && !partial_word_o)
    else $error("taken pulse too long");
  a_word_held: assert property (!word_taken_o && $past(rst_n_i) |-> $stable(input_word_o))
    else $error("input word moved without a full word");
  a_latch_held: assert property (!latch_update_o && $past(rst_n_i) |-> $stable(dac_code_o))
    else $error("code moved without update pulse");
  a_latch_transparent: assert property ((!latch_load_n_i && $stable(input_word_o)
    && $stable(data_format_select_i))[*5] |-> dac_code_o == (input_word_o
    ^ (data_format_select_i ? 16'h0000 : 16'h8000))) else $error("latch not following word");
  a_power_down_follow: assert property ($stable(power_down_in_i)[*5]
    |-> power_down_o == power_down_in_i) else $error("power down state wrong");
  a_readback_first_bit: assert property ($fell(cs_n_i) && serial_out_select_i
    |-> sdo_o == input_word_o[15]) else $error("readback first bit wrong");
  c_full_word: cover property (word_taken_o);
  c_partial: cover property (partial_word_o);
  c_latch: cover property (latch_update_o);
endmodule
bind sdac_top sdac_top_monitor i_sdac_top_monitor (.clock_i, .rst_n_i, .cs_n_i, .sdo_o,
  .sdo_oe_n_o, .latch_load_n_i, .reset_level_select_i, .data_format_select_i, .power_down_in_i,
  .serial_out_select_i, .dac_code_o, .power_down_o, .input_word_o, .word_taken_o,
  .partial_word_o, .latch_update_o);
`default_nettype wire

// ===== sim/sdac_host_model.sv
// serial host model: clock, chip select and data out, readback sampling
`timescale 1ns/1ns
`default_nettype none
module sdac_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // msb first; clock stands still outside frames; sdo taken before each rise
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rd);
    rd = 32'h0000_0000;
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o = w[i];
      #7;
      rd = {rd[30:0], sdo_i};
      sclk_o = 1'b1;
      #8;
      sclk_o = 1'b0;
    end
    #7;
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #40;
  endtask
endmodule
`default_nettype wire

// ===== sim/sdac_top_tb.sv
// self-checking bench for the serial converter front end
`timescale 1ns/1ns
`default_nettype none
module sdac_top_tb;
  logic clock_i = 1'b0;
  logic rst_n = 1'b0;
  logic ld_n = 1'b1;
  logic lvl = 1'b1;
  logic fmt = 1'b1;
  logic pd = 1'b0;
  logic sos = 1'b1;
  logic saw_part = 1'b0;
  logic [31:0] rd;
  wire logic sclk, cs_n, sdi, sdo, oe_n, pd_o, taken, part, upd, sdo_pin;
  wire logic [15:0] dac, word;
  int err_total = 0;
  int n_compared = 0;
  assign sdo_pin = oe_n ? 1'bz : sdo;
  always #2 clock_i = ~clock_i;
  always @(posedge clock_i) if (part) saw_part <= 1'b1;
  sdac_top i_sdac_top (.clock_i, .rst_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_n_o(oe_n), .latch_load_n_i(ld_n), .reset_level_select_i(lvl),
    .data_format_select_i(fmt), .power_down_in_i(pd), .serial_out_select_i(sos),
    .dac_code_o(dac), .power_down_o(pd_o), .input_word_o(word), .word_taken_o(taken),
    .partial_word_o(part), .latch_update_o(upd));
  sdac_host_model i_sdac_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_pin));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_reset(input logic level);
    @(posedge clock_i);
    rst_n <= 1'b0;
    lvl <= level;
    wait_clk(20);
    @(posedge clock_i);
    rst_n <= 1'b1;
    wait_clk(2);
    chk("reset word", {level, 15'h0000}, word);
    chk("reset code", {level, 15'h0000}, dac);
  endtask
  task automatic t_write;
    i_sdac_host_model.xfer(32'h0000_1234, 16, rd);
    wait_clk(6);
    chk("word", 16'h1234, word);
    chk("closed latch", 16'h0000, dac);
    chk("sdo enable idle", 16'h0001, {15'h0000, oe_n});
    @(posedge clock_i);
    ld_n <= 1'b0;
    wait_clk(6);
    chk("open latch", 16'h1234, dac);
    @(posedge clock_i);
    fmt <= 1'b0;
    wait_clk(6);
    chk("twos code", 16'h9234, dac);
    @(posedge clock_i);
    fmt <= 1'b1;
    wait_clk(4);
  endtask
  task automatic t_serial_out;
    i_sdac_host_model.xfer(32'h0000_abcd, 16, rd);
    wait_clk(6);
    chk("readback", 16'h1234, rd[15:0]);
    chk("latched word", 16'habcd, dac);
    @(posedge clock_i);
    sos <= 1'b0;
    wait_clk(4);
    i_sdac_host_model.xfer(32'h5a5a_c3c3, 32, rd);
    wait_clk(6);
    chk("daisy out", 16'h5a5a, rd[15:0]);
    chk("last 16 kept", 16'hc3c3, word);
    i_sdac_host_model.xfer(32'h0000_00ff, 8, rd);
    wait_clk(6);
    chk("partial kept", 16'hc3c3, word);
    chk("partial seen", 16'h0001, {15'h0000, saw_part});
  endtask
  task automatic t_power;
    @(posedge clock_i);
    pd <= 1'b1;
    wait_clk(5);
    chk("power down on", 16'h0001, {15'h0000, pd_o});
    @(posedge clock_i);
    pd <= 1'b0;
    wait_clk(5);
    chk("power down off", 16'h0000, {15'h0000, pd_o});
  endtask
  initial begin
    t_reset(1'b1);
    t_reset(1'b0);
    t_write();
    t_serial_out();
    t_power();
    end_of_test();
  end
  initial begin
    #20000;
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
